/* design/fpc_coding.sv */
`timescale 1ns/1ps
`default_nettype none
module fpc_coding #(
	parameter int unsigned HOLD_CYCLES = fpc_pkg::HOLD_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// straps
	input wire logic [4:0] phy_address_straps,
	// mac transmit
	input wire logic tx_en,
	input wire logic [3:0] txd,
	output logic tx_nib_take,
	// line transmit
	output logic tx_drive_pos,
	output logic tx_drive_neg,
	// line receive
	input wire logic rx_level_pos,
	input wire logic rx_level_neg,
	// mac receive
	output logic rx_group_valid,
	output logic [4:0] rx_group,
	output logic [3:0] rx_nibble,
	output logic rx_code_err,
	output logic sig_detect
);
	localparam logic [fpc_pkg::HOLD_W-1:0] HOLD_LOAD = HOLD_CYCLES[fpc_pkg::HOLD_W-1:0];
	localparam logic [fpc_pkg::HOLD_W-1:0] HOLD_ONE = 17'h00001;

	typedef struct packed {
		fpc_pkg::fpc_tx_state_type tx_state;
		logic [2:0] bit_cnt;
		logic [4:0] tx_shift;
		logic nib_take;
		logic seeded;
		logic [10:0] scr;
		logic tx_bit;
		logic [10:0] dsc;
		logic locked;
		logic [5:0] ones_run;
		logic [fpc_pkg::HOLD_W-1:0] hold;
		logic [2:0] rx_cnt;
		logic [4:0] rx_shift;
		logic [4:0] rx_group;
		logic rx_valid;
		logic [3:0] rx_nibble;
		logic rx_err;
	} fpc_state_type;

	fpc_state_type cur;
	fpc_state_type next_cur;
	logic rx_nrz;
	logic scr_key;
	logic dsc_key;
	logic rx_ud;
	logic cg_end;
	logic idle_seen;
	logic [4:0] dec;

	fpc_line_coder u_line (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.tx_nrz(cur.tx_bit),
		.tx_drive_pos(tx_drive_pos),
		.tx_drive_neg(tx_drive_neg),
		.rx_level_pos(rx_level_pos),
		.rx_level_neg(rx_level_neg),
		.rx_nrz(rx_nrz)
	);

	always_comb begin
		next_cur = cur;
		cg_end = (cur.bit_cnt == fpc_pkg::CG_LAST);
		scr_key = cur.scr[fpc_pkg::TAP_HI] ^ cur.scr[fpc_pkg::TAP_LO];
		dsc_key = cur.dsc[fpc_pkg::TAP_HI] ^ cur.dsc[fpc_pkg::TAP_LO];
		rx_ud = rx_nrz ^ dsc_key;
		idle_seen = 1'b0;
		dec = fpc_pkg::fpc_decode({cur.rx_shift[3:0], rx_ud});

		// transmit: symbol counter and code-group loader
		next_cur.bit_cnt = cg_end ? 3'h0 : cur.bit_cnt + 3'h1;
		// strobe shows in the same cycle as the load so the mac sees its nibble taken
		next_cur.nib_take = (cur.bit_cnt == 3'h3);
		next_cur.tx_shift = {cur.tx_shift[3:0], 1'b0};
		if (cg_end) begin
			unique case (cur.tx_state)
				fpc_pkg::FPC_TX_IDLE: begin
					if (tx_en) begin
						next_cur.tx_state = fpc_pkg::FPC_TX_SJ;
						next_cur.tx_shift = fpc_pkg::CG_J;
					end else begin
						next_cur.tx_shift = fpc_pkg::CG_I;
					end
				end
				fpc_pkg::FPC_TX_SJ: begin
					next_cur.tx_state = fpc_pkg::FPC_TX_SK;
					next_cur.tx_shift = fpc_pkg::CG_K;
				end
				fpc_pkg::FPC_TX_SK, fpc_pkg::FPC_TX_DATA: begin
					if (tx_en) begin
						next_cur.tx_state = fpc_pkg::FPC_TX_DATA;
						next_cur.tx_shift = fpc_pkg::fpc_encode(txd);
					end else begin
						next_cur.tx_state = fpc_pkg::FPC_TX_ET;
						next_cur.tx_shift = fpc_pkg::CG_T;
					end
				end
				fpc_pkg::FPC_TX_ET: begin
					next_cur.tx_state = fpc_pkg::FPC_TX_ER;
					next_cur.tx_shift = fpc_pkg::CG_R;
				end
				fpc_pkg::FPC_TX_ER: begin
					// no back-to-back frame: one idle group always follows the end pair
					next_cur.tx_state = fpc_pkg::FPC_TX_IDLE;
					next_cur.tx_shift = fpc_pkg::CG_I;
				end
				default: begin
					next_cur.tx_state = fpc_pkg::FPC_TX_IDLE;
					next_cur.tx_shift = fpc_pkg::CG_I;
				end
			endcase
		end

		// transmit scrambler, seeded once after reset from the straps
		if (!cur.seeded) begin
			next_cur.seeded = 1'b1;
			next_cur.scr = {phy_address_straps[4:1], fpc_pkg::SEED_LOW};
		end else begin
			next_cur.scr = {cur.scr[9:0], scr_key};
		end
		next_cur.tx_bit = cur.tx_shift[4] ^ scr_key;

		// receive: idle run length on the descrambled stream
		if (rx_ud) begin
			next_cur.ones_run = (cur.ones_run == 6'h3F) ? cur.ones_run : cur.ones_run + 6'h01;
		end else begin
			next_cur.ones_run = 6'h00;
		end
		next_cur.rx_valid = 1'b0;

		if (!cur.locked) begin
			// acquisition assumes idle, so the key bit is the inverted line bit
			next_cur.dsc = {cur.dsc[9:0], ~rx_nrz};
			next_cur.rx_cnt = 3'h0;
			if (rx_ud && cur.ones_run == fpc_pkg::LOCK_BITS - 6'h01) begin
				next_cur.locked = 1'b1;
				next_cur.hold = HOLD_LOAD;
			end
		end else begin
			next_cur.dsc = {cur.dsc[9:0], dsc_key};
			idle_seen = rx_ud && cur.ones_run == fpc_pkg::IDLE_HOLD_BITS - 6'h01;
			if (idle_seen) begin
				next_cur.hold = HOLD_LOAD;
			end else if (cur.hold == HOLD_ONE) begin
				// full restart: key register set to LFSR_RESET; run counter, hold timer and group bit counter cleared
				next_cur.locked = 1'b0;
				next_cur.dsc = fpc_pkg::LFSR_RESET;
				next_cur.ones_run = 6'h00;
				next_cur.hold = '0;
				next_cur.rx_cnt = 3'h0;
			end else begin
				next_cur.hold = cur.hold - HOLD_ONE;
			end
			if (next_cur.locked) begin
				next_cur.rx_shift = {cur.rx_shift[3:0], rx_ud};
				next_cur.rx_cnt = (cur.rx_cnt == fpc_pkg::CG_LAST) ? 3'h0 : cur.rx_cnt + 3'h1;
				if (cur.rx_cnt == fpc_pkg::CG_LAST) begin
					// groups are unaligned; alignment happens downstream
					next_cur.rx_valid = 1'b1;
					next_cur.rx_group = {cur.rx_shift[3:0], rx_ud};
					next_cur.rx_nibble = dec[3:0];
					next_cur.rx_err = dec[4];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
			cur.tx_state <= fpc_pkg::FPC_TX_IDLE;
			cur.tx_shift <= fpc_pkg::CG_I;
			cur.scr <= fpc_pkg::LFSR_RESET;
			cur.dsc <= fpc_pkg::LFSR_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	assign tx_nib_take = cur.nib_take;
	assign rx_group_valid = cur.rx_valid;
	assign rx_group = cur.rx_group;
	assign rx_nibble = cur.rx_nibble;
	assign rx_code_err = cur.rx_err;
	// only a locked descrambler counts, so link pulses never raise it
	assign sig_detect = cur.locked;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_gap4;
		!tx_nib_take [*4];
	endsequence

	sequence s_end_pair;
		cur.tx_shift == fpc_pkg::CG_T ##5 cur.tx_shift == fpc_pkg::CG_R;
	endsequence

	sequence s_start_pair;
		cur.tx_shift == fpc_pkg::CG_J ##5 cur.tx_shift == fpc_pkg::CG_K;
	endsequence

	AST_NIB_PERIOD: assert property (tx_nib_take |=> s_gap4 ##1 tx_nib_take)
		else $error("nibble strobe not every five cycles");
	AST_START_PAIR: assert property (tx_nib_take && tx_en && cur.tx_state == fpc_pkg::FPC_TX_IDLE
		|=> s_start_pair)
		else $error("start pair missing");
	AST_DATA_CODE: assert property (tx_nib_take && tx_en
		&& (cur.tx_state == fpc_pkg::FPC_TX_SK || cur.tx_state == fpc_pkg::FPC_TX_DATA)
		|=> cur.tx_shift == fpc_pkg::fpc_encode($past(txd)))
		else $error("data code-group wrong");
	AST_END_PAIR: assert property (tx_nib_take && !tx_en && cur.tx_state == fpc_pkg::FPC_TX_DATA
		|=> s_end_pair ##5 cur.tx_shift == fpc_pkg::CG_I)
		else $error("end pair missing");
	AST_IDLE_FILL: assert property (cur.tx_state == fpc_pkg::FPC_TX_IDLE && cur.bit_cnt == 3'h0
		&& $past(cur.bit_cnt) == fpc_pkg::CG_LAST |-> cur.tx_shift == fpc_pkg::CG_I)
		else $error("idle not sent between frames");
	AST_SEED: assert property ($rose(cur.seeded) |-> cur.scr[10:7] == $past(phy_address_straps[4:1]))
		else $error("scrambler seed not from straps");
	AST_LOCK_RUN: assert property ($rose(cur.locked) |-> $past(cur.ones_run) == fpc_pkg::LOCK_BITS - 6'h01
		&& cur.hold == HOLD_LOAD)
		else $error("lock without twelve idle groups");
	AST_HOLD_DROP: assert property (cur.locked && cur.hold == HOLD_ONE && !idle_seen
		|=> !cur.locked && cur.ones_run == 6'h00 && cur.dsc == fpc_pkg::LFSR_RESET)
		else $error("hold expiry did not drop lock");
	AST_HOLD_RESTART: assert property (cur.locked && idle_seen |=> cur.hold == HOLD_LOAD)
		else $error("idle did not restart hold timer");
	AST_GROUP_GAP: assert property (rx_group_valid |=> !rx_group_valid [*4])
		else $error("receive groups closer than five bits");
	AST_DECODE: assert property (rx_group_valid && !rx_code_err
		|-> fpc_pkg::fpc_encode(rx_nibble) == rx_group)
		else $error("receive nibble does not match group");
endmodule : fpc_coding
`default_nettype wire

/* design/fpc_pkg.sv */
// How it works
// - each transmit nibble from the MAC becomes a 5-bit code-group before serialising
// - standard 4B5B mapping; control code-groups decoded on receive are flagged invalid
// - first two preamble nibbles of a frame are sent as 11000 then 10001
// - after the start pair, every further nibble goes out as its code-group
// - when transmit enable drops, 01101 then 00111 close the frame
// - after the end pair, idle code-groups flow until transmit enable returns
// - scrambler is a free-running 11-stage LFSR xored onto the serial NRZ bits
// - scrambler seed comes from address straps [4:1]; straps differing only in bit 0 give the same seed
// - scrambled transmit bits are NRZI encoded before the driver stage
// - ones of the NRZI stream alternate between two binary drive streams
// - transmit output is always MLT-3; no binary output mode exists
// - receive turns the three-level stream into 4-bit nibbles for the MAC
// - three-level receive symbols go to NRZI, then to NRZ, before descrambling
// - received bits are grouped into 5-bit symbols
// - descrambler makes the far-end key sequence and xors it off the data
// - lock after twelve idle code-groups of ones; then unaligned groups come out
// - lock starts a 722 us hold timer; 58 idle bit times restart it
// - hold timer expiry without enough idle drops lock and restarts acquisition
// - signal detect never rises on 10 Mb/s link pulses or fast link pulses
package fpc_pkg;
	// clock and timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned HOLD_TIME_US = 722;
	localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_US * CLK_MHZ;
	localparam int unsigned HOLD_W = 17;
	localparam logic [5:0] IDLE_HOLD_BITS = 6'h3A;
	localparam logic [5:0] LOCK_BITS = 6'h3C;
	localparam logic [2:0] CG_LAST = 3'h4;
	// scrambler
	localparam logic [10:0] LFSR_RESET = 11'h7FF;
	localparam logic [6:0] SEED_LOW = 7'h5A;
	localparam int unsigned TAP_HI = 10;
	localparam int unsigned TAP_LO = 8;
	// control code-groups
	localparam logic [4:0] CG_I = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;

	typedef enum logic [5:0] {
		FPC_TX_IDLE = 6'h01,
		FPC_TX_SJ = 6'h02,
		FPC_TX_SK = 6'h04,
		FPC_TX_DATA = 6'h08,
		FPC_TX_ET = 6'h10,
		FPC_TX_ER = 6'h20
	} fpc_tx_state_type;

	function automatic logic [4:0] fpc_encode(input logic [3:0] nib);
		logic [4:0] cg;
		cg = 5'h1E;
		unique case (nib)
			4'h0: cg = 5'h1E;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0A;
			4'h5: cg = 5'h0B;
			4'h6: cg = 5'h0E;
			4'h7: cg = 5'h0F;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'hA: cg = 5'h16;
			4'hB: cg = 5'h17;
			4'hC: cg = 5'h1A;
			4'hD: cg = 5'h1B;
			4'hE: cg = 5'h1C;
			4'hF: cg = 5'h1D;
		endcase
		return cg;
	endfunction : fpc_encode

	// bit 4 set means not a data code-group
	function automatic logic [4:0] fpc_decode(input logic [4:0] cg);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (fpc_encode(4'(i)) == cg) begin
				r = {1'b0, 4'(i)};
			end
		end
		return r;
	endfunction : fpc_decode
endpackage : fpc_pkg

`timescale 1ns/1ps
`default_nettype none
module fpc_line_coder (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// transmit side
	input wire logic tx_nrz,
	output logic tx_drive_pos,
	output logic tx_drive_neg,
	// receive side
	input wire logic rx_level_pos,
	input wire logic rx_level_neg,
	output logic rx_nrz
);
	typedef struct packed {
		logic nrzi;
		logic [1:0] phase;
		logic pos;
		logic neg;
		logic rx_nrzi;
		logic rx_nrz;
	} fpc_coder_type;

	fpc_coder_type cur;
	fpc_coder_type next_cur;
	logic rx_nrzi_in;

	always_comb begin
		next_cur = cur;
		next_cur.nrzi = cur.nrzi ^ tx_nrz;
		// each NRZI transition steps 0,+,0,- so ones alternate pos and neg
		next_cur.phase = cur.phase + {1'b0, next_cur.nrzi ^ cur.nrzi};
		next_cur.pos = (next_cur.phase == 2'h1);
		next_cur.neg = (next_cur.phase == 2'h3);
		rx_nrzi_in = rx_level_pos | rx_level_neg;
		next_cur.rx_nrzi = rx_nrzi_in;
		next_cur.rx_nrz = rx_nrzi_in ^ cur.rx_nrzi;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tx_drive_pos = cur.pos;
	assign tx_drive_neg = cur.neg;
	assign rx_nrz = cur.rx_nrz;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	AST_DRIVE_EXCLUSIVE: assert property (!(tx_drive_pos && tx_drive_neg))
		else $error("both drive streams active");
	AST_NRZI_TOGGLE: assert property (##1 (cur.nrzi != $past(cur.nrzi)) == $past(tx_nrz))
		else $error("nrzi does not follow tx bit");
	AST_RX_NRZ: assert property (##2 rx_nrz == ($past(rx_level_pos | rx_level_neg)
		^ $past(rx_level_pos | rx_level_neg, 2)))
		else $error("receive nrz decode wrong");
endmodule : fpc_line_coder
`default_nettype wire

/* tb/fpc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpc_mac_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// bench control
	input wire logic go,
	input wire logic [7:0] frame_len,
	output logic busy,
	// mii transmit
	input wire logic tx_nib_take,
	output logic tx_en,
	output logic [3:0] txd
);
	logic [7:0] idx;
	// two preamble nibbles, then a counting pattern
	function automatic logic [3:0] nib(input logic [7:0] i);
		return (i < 8'h02) ? 4'h5 : 4'(i - 8'h02);
	endfunction : nib
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			idx <= 8'h00;
			tx_en <= 1'b0;
			txd <= 4'h0;
		end else if (!busy) begin
			if (go) begin
				busy <= 1'b1;
				idx <= 8'h00;
				tx_en <= 1'b1;
				txd <= 4'h5;
			end else begin
				// idle nibble lines toggle so stale data is never mistaken
				txd <= ~txd;
			end
		end else if (tx_nib_take) begin
			// held through the take cycle, changed only at its edge
			if (idx + 8'h01 == frame_len) begin
				busy <= 1'b0;
				tx_en <= 1'b0;
				txd <= ~txd;
			end else begin
				idx <= idx + 8'h01;
				txd <= nib(idx + 8'h01);
			end
		end
	end
endmodule : fpc_mac_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned HOLD = 300;
	localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic clk_sys;
	logic rst_b;
	logic go;
	logic [7:0] frame_len;
	logic busy;
	logic tx_en;
	logic [3:0] txd;
	logic tx_nib_take;
	logic drv_pos;
	logic drv_neg;
	logic alt_pos;
	logic alt_neg;
	logic rx_group_valid;
	logic [4:0] rx_group;
	logic [3:0] rx_nibble;
	logic rx_code_err;
	logic sig_detect;
	int err_count;
	int cmp_count;
	logic bits [$];
	bit collect;
	bit low_seen;
	bit last_neg;
	bit was_nz;
	bit seen_diff;

	// line looped back so receive sees our own transmit
	fpc_coding #(.HOLD_CYCLES(HOLD)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.phy_address_straps(5'h16), .tx_en(tx_en), .txd(txd), .tx_nib_take(tx_nib_take),
		.tx_drive_pos(drv_pos), .tx_drive_neg(drv_neg), .rx_level_pos(drv_pos), .rx_level_neg(drv_neg),
		.rx_group_valid(rx_group_valid), .rx_group(rx_group), .rx_nibble(rx_nibble),
		.rx_code_err(rx_code_err), .sig_detect(sig_detect));
	// second part with other straps, only its line output is watched
	fpc_coding #(.HOLD_CYCLES(HOLD)) uut_alt (.clk_sys(clk_sys), .rst_b(rst_b),
		.phy_address_straps(5'h08), .tx_en(tx_en), .txd(txd), .tx_nib_take(),
		.tx_drive_pos(alt_pos), .tx_drive_neg(alt_neg), .rx_level_pos(alt_pos), .rx_level_neg(alt_neg),
		.rx_group_valid(), .rx_group(), .rx_nibble(), .rx_code_err(), .sig_detect());
	fpc_mac_model mac (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .frame_len(frame_len), .busy(busy),
		.tx_nib_take(tx_nib_take), .tx_en(tx_en), .txd(txd));

	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	function automatic logic [4:0] lookup(input logic [4:0] g);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 0; i < 16; i++) begin
			if (ENC[i] === g) begin
				r = {1'b0, 4'(i)};
			end
		end
		return r;
	endfunction : lookup

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// line and receive monitor, sampled mid-cycle
	always @(negedge clk_sys) begin
		if (rst_b === 1'b1) begin
			check(!(drv_pos && drv_neg), "both drives high");
			if ((drv_pos || drv_neg) && !was_nz) begin
				check(drv_pos === last_neg, "three-level steps not alternating");
				last_neg = drv_neg;
			end
			was_nz = drv_pos | drv_neg;
			if (drv_pos !== alt_pos || drv_neg !== alt_neg) seen_diff = 1'b1;
			if (sig_detect !== 1'b1) low_seen = 1'b1;
			if (rx_group_valid === 1'b1) begin
				check(sig_detect === 1'b1, "group while unlocked");
				check(rx_code_err === lookup(rx_group)[4], "code error flag");
				check(rx_nibble === (lookup(rx_group)[4] ? 4'h0 : lookup(rx_group)[3:0]), "nibble");
				if (collect) begin
					for (int k = 4; k >= 0; k--) bits.push_back(rx_group[k]);
				end
			end
		end
	end

	task automatic wait_lock(input int bound);
		int n;
		n = 0;
		while (sig_detect !== 1'b1 && n < bound) begin
			@(posedge clk_sys);
			n++;
		end
		check(sig_detect === 1'b1, "no lock on idle");
	endtask : wait_lock

	task automatic send(input logic [7:0] len);
		int n;
		n = 0;
		@(posedge clk_sys);
		frame_len <= len;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		while (busy === 1'b1 && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		check(busy === 1'b0, "frame never completed");
	endtask : send

	task automatic t_lock();
		last_neg = 1'b1;
		repeat (20) @(posedge clk_sys);
		check(sig_detect === 1'b0, "lock before twelve idles");
		wait_lock(1000);
		check(seen_diff === 1'b1, "straps do not change scrambling");
	endtask : t_lock

	task automatic t_frame();
		int z;
		int st;
		logic [4:0] exp [$];
		z = -1;
		bits.delete();
		low_seen = 1'b0;
		collect = 1'b1;
		send(8'd18);
		repeat (60) @(posedge clk_sys);
		collect = 1'b0;
		exp = {fpc_pkg::CG_J, fpc_pkg::CG_K};
		for (int i = 0; i < 16; i++) exp.push_back(ENC[i]);
		exp.push_back(fpc_pkg::CG_T);
		exp.push_back(fpc_pkg::CG_R);
		exp.push_back(fpc_pkg::CG_I);
		foreach (bits[i]) if (z < 0 && bits[i] === 1'b0) z = i;
		st = z - 2;
		check(st >= 0 && bits.size() >= st + 5 * exp.size(), "frame not seen");
		if (st >= 0 && bits.size() >= st + 5 * exp.size()) begin
			foreach (exp[g]) for (int k = 0; k < 5; k++) check(bits[st + 5 * g + k] === exp[g][4 - k], "group bit");
		end
		check(low_seen === 1'b0, "lock lost in short frame");
	endtask : t_frame

	task automatic t_hold();
		low_seen = 1'b0;
		send(8'd130);
		check(low_seen === 1'b1, "lock held without idle");
		wait_lock(600);
	endtask : t_hold

	task automatic summarize();
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	initial begin
		#100us;
		err_count++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		go = 1'b0;
		frame_len = 8'h00;
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_lock();
		t_frame();
		t_hold();
		summarize();
	end
endmodule : testbench
`default_nettype wire
